/* include/lbd_alu_if.sv */
// Purpose: Carrier between the decoder core and its arithmetic unit.
// Assumes: Purely combinational exchange inside one clock domain.
// Notes:   The core drives operands; the unit answers in the same cycle.
`default_nettype none

interface lbd_alu_if;
	import lbd_pkg::*;
	logic [7:0]     opA;
	logic [7:0]     opB;
	logic           carryIn;
	lbd_alu_op_type op;
	logic [7:0]     result;
	logic           carryOut;
	logic           digitCarry;
	logic           overflow;

	modport core (output opA, opB, carryIn, op, input result, carryOut, digitCarry, overflow);
	modport alu  (input opA, opB, carryIn, op, output result, carryOut, digitCarry, overflow);
endinterface

`default_nettype wire

/* include/lbd_pkg.sv */
// Purpose: Shared constants and types for the logic, bit-clear and branch decoder.
// Assumes: One core clock; four core clocks make one instruction cycle.
// Notes:   Opcode fields are matched on the upper bits of the 16-bit instruction word.
`default_nettype none

package lbd_pkg;

	// ------------------------------------------------------------
	// Widths
	// ------------------------------------------------------------
	localparam int PC_W    = 21;
	localparam int DATA_W  = 8;
	localparam int FADDR_W = 12;
	localparam int FLAG_W  = 5;

	// ------------------------------------------------------------
	// Opcodes and instruction fields
	// ------------------------------------------------------------
	localparam logic [7:0] OPC_AND_IMM   = 8'h0b;  // Bits 15:8.
	localparam logic [5:0] OPC_AND_FILE  = 6'h05;  // Bits 15:10.
	localparam logic [5:0] OPC_ADD_CARRY = 6'h08;  // Bits 15:10.
	localparam logic [3:0] OPC_BIT_CLR   = 4'h9;   // Bits 15:12.
	localparam logic [7:0] OPC_BR_CS     = 8'he2;  // Bits 15:8.
	localparam logic [7:0] OPC_BR_NS     = 8'he6;
	localparam logic [7:0] OPC_BR_CC     = 8'he3;
	localparam int         DEST_BIT      = 9;
	localparam int         BANK_ACC_BIT  = 8;
	localparam int         BIT_SEL_LSB   = 9;
	localparam logic [15:0] INSTR_NOP    = 16'h0000;

	// ------------------------------------------------------------
	// Fixed window bank and reset values
	// ------------------------------------------------------------
	localparam int         WINDOW_SPLIT_BIT = 7;
	localparam logic [3:0] WINDOW_LO_BANK   = 4'h0;
	localparam logic [3:0] WINDOW_HI_BANK   = 4'hf;
	localparam logic [PC_W-1:0]   PC_RST    = 21'h00000;
	localparam logic [PC_W-1:0]   PC_STEP   = 21'h00002;
	localparam logic [DATA_W-1:0] ACCUM_RST = 8'h00;
	localparam logic [FLAG_W-1:0] FLAG_RST  = 5'h00;

	// ------------------------------------------------------------
	// Status flag positions
	// ------------------------------------------------------------
	localparam int FLG_C  = 0;
	localparam int FLG_DC = 1;
	localparam int FLG_Z  = 2;
	localparam int FLG_OV = 3;
	localparam int FLG_N  = 4;

	// ------------------------------------------------------------
	// Phases and arithmetic operations
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		PH_Q1 = 4'b0001,
		PH_Q2 = 4'b0010,
		PH_Q3 = 4'b0100,
		PH_Q4 = 4'b1000
	} lbd_phase_type;

	typedef enum logic [2:0] {
		ALU_PASS = 3'b001,
		ALU_AND  = 3'b010,
		ALU_ADC  = 3'b100
	} lbd_alu_op_type;

endpackage

`default_nettype wire

/* rtl/lbd_alu.sv */
// Purpose: Eight-bit AND and add-with-carry unit for the decoder core.
// Assumes: Operands are stable for the whole phase in which they are used.
// Notes:   Flags other than carry, digit carry and overflow are formed by the core.
`default_nettype none

module lbd_alu
	import lbd_pkg::*;
(
	// Operands and answer.
	lbd_alu_if.alu bus
);

	// ------------------------------------------------------------
	// Sums
	// ------------------------------------------------------------
	// Nibble and byte sums are kept one bit wider to expose the carries.
	logic [4:0] lowSum;
	logic [8:0] fullSum;

	assign lowSum  = {1'b0, bus.opA[3:0]} + {1'b0, bus.opB[3:0]} + {4'h0, bus.carryIn};
	assign fullSum = {1'b0, bus.opA} + {1'b0, bus.opB} + {8'h00, bus.carryIn};

	// Result selection; an unknown operation passes the second operand.
	always_comb begin
		bus.result     = bus.opB;
		bus.carryOut   = 1'b0;
		bus.digitCarry = 1'b0;
		bus.overflow   = 1'b0;
		case (bus.op)
			ALU_AND: begin
				bus.result = bus.opA & bus.opB;
			end
			ALU_ADC: begin
				bus.result     = fullSum[7:0];
				bus.carryOut   = fullSum[8];
				bus.digitCarry = lowSum[4];
				bus.overflow   = (bus.opA[7] == bus.opB[7]) && (fullSum[7] != bus.opA[7]);
			end
			default: begin
				bus.result = bus.opB;
			end
		endcase
	end

endmodule // lbd_alu

`default_nettype wire

/* rtl/lbd_core.sv */
// Purpose: Decode and execute AND, add-with-carry, bit clear and three conditional branches.
// Assumes: instrData holds the prefetched word at the edge that closes phase Q1.
// Notes:   One instruction cycle is four core clocks, phases Q1 to Q4.
// Contract
// - AND immediate: accumulator gets AND, flags N,Z
// - AND file: AND with file, flags N,Z
// - Destination bit: 0 accumulator, 1 file register
// - Bank bit: 0 fixed window, 1 bank pointer
// - Bit clear: one file bit, flags untouched
// - Taken branch: counter plus twice signed offset
// - Branch: one cycle, two when taken
// - Carry-set branch only when carry is one
// - Negative-set branch only when negative is one
// - Carry-clear branch only when carry is zero
// - Add with carry: all five flags, routed result
`default_nettype none

module lbd_core
	import lbd_pkg::*;
(
	// Clock and reset.
	input  wire logic                core_clk,
	input  wire logic                rst_n,
	// Instruction fetch.
	input  wire logic [15:0]         instrData,
	output logic      [PC_W-1:0]     pc_r,
	output logic                     fetchStrobe_r,
	output logic                     flushCycle_r,
	// File register array.
	input  wire logic [3:0]          bankPointer,
	input  wire logic [DATA_W-1:0]   fileRdData,
	output logic      [FADDR_W-1:0]  fileAddr_r,
	output logic      [DATA_W-1:0]   fileWrData_r,
	output logic                     fileWe_r,
	// Core state.
	output logic      [DATA_W-1:0]   accum_r,
	output logic      [FLAG_W-1:0]   statusFlags_r
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// Full file address from the bank-access bit, the pointer and the low byte.
	function automatic logic [FADDR_W-1:0] fileAddress(input logic [15:0] word,
			input logic [3:0] bank);
		logic [3:0] winBank;
		winBank = word[WINDOW_SPLIT_BIT] ? WINDOW_HI_BANK : WINDOW_LO_BANK;
		fileAddress = {(word[BANK_ACC_BIT] ? bank : winBank), word[7:0]};
	endfunction

	// One-hot mask for the bit-select field.
	function automatic logic [DATA_W-1:0] bitMask(input logic [15:0] word);
		bitMask = 8'h01 << word[BIT_SEL_LSB +: 3];
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	lbd_phase_type     phase_r;
	lbd_phase_type     phase_nxt;
	logic [15:0]       instr_r;
	logic [DATA_W-1:0] operand_r;
	lbd_alu_if         aluBus ();

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	logic isAndImm, isAndFile, isAddCarry, isBitClr;
	logic isBrCs, isBrNs, isBrCc, brTaken;
	logic destFile, writeFile, writeAccum;
	logic [DATA_W-1:0] resultNxt;
	logic [FLAG_W-1:0] flagsNxt;
	logic [PC_W-1:0]   branchOffset;
	logic [PC_W-1:0]   pcNxt;

	// Opcodes match on their fixed upper bits; the low byte is always the operand.
	assign isAndImm   = instr_r[15:8] == OPC_AND_IMM;
	assign isAndFile  = instr_r[15:10] == OPC_AND_FILE;
	assign isAddCarry = instr_r[15:10] == OPC_ADD_CARRY;
	assign isBitClr   = instr_r[15:12] == OPC_BIT_CLR;
	assign isBrCs     = instr_r[15:8] == OPC_BR_CS;
	assign isBrNs     = instr_r[15:8] == OPC_BR_NS;
	assign isBrCc     = instr_r[15:8] == OPC_BR_CC;

	// Branch conditions on the flags as they stand when the branch executes.
	assign brTaken = (isBrCs && statusFlags_r[FLG_C])
		|| (isBrNs && statusFlags_r[FLG_N])
		|| (isBrCc && !statusFlags_r[FLG_C]);

	// Destination routing for the byte operations.
	assign destFile   = instr_r[DEST_BIT];
	assign writeFile  = ((isAndFile || isAddCarry) && destFile) || isBitClr;
	assign writeAccum = isAndImm || ((isAndFile || isAddCarry) && !destFile);

	// ------------------------------------------------------------
	// Arithmetic unit hookup
	// ------------------------------------------------------------
	assign aluBus.opA     = accum_r;
	assign aluBus.opB     = isAndImm ? instr_r[7:0] : operand_r;
	assign aluBus.carryIn = statusFlags_r[FLG_C];
	assign aluBus.op      = (isAndImm || isAndFile) ? ALU_AND :
		(isAddCarry ? ALU_ADC : ALU_PASS);

	// The unit is purely combinational, so its answer is ready within the same phase.
	lbd_alu uAlu (
		.bus (aluBus.alu)
	);

	// Bit clear touches one bit; everything else comes from the unit.
	assign resultNxt = isBitClr ? (operand_r & ~bitMask(instr_r)) : aluBus.result;

	// Flag update: AND sets N and Z only, add sets all five, others keep them.
	always_comb begin
		flagsNxt = statusFlags_r;
		if (isAndImm || isAndFile || isAddCarry) begin
			flagsNxt[FLG_N] = resultNxt[7];
			flagsNxt[FLG_Z] = resultNxt == 8'h00;
		end
		if (isAddCarry) begin
			flagsNxt[FLG_C]  = aluBus.carryOut;
			flagsNxt[FLG_DC] = aluBus.digitCarry;
			flagsNxt[FLG_OV] = aluBus.overflow;
		end
	end

	// The counter already points past the branch, so the target is pc + 2n.
	assign branchOffset = {{(PC_W - 9){instr_r[7]}}, instr_r[7:0], 1'b0};
	assign pcNxt        = brTaken ? (pc_r + branchOffset) : (pc_r + PC_STEP);

	// ------------------------------------------------------------
	// Phase ring
	// ------------------------------------------------------------
	// One-hot ring; an illegal code falls back to Q1 rather than locking the core up.
	always_comb begin
		case (phase_r)
			PH_Q1:   phase_nxt = PH_Q2;
			PH_Q2:   phase_nxt = PH_Q3;
			PH_Q3:   phase_nxt = PH_Q4;
			PH_Q4:   phase_nxt = PH_Q1;
			default: phase_nxt = PH_Q1;
		endcase
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_r <= PH_Q1;
		end else begin
			phase_r <= phase_nxt;
		end
	end

	// ------------------------------------------------------------
	// Q1 decode and Q2 operand read
	// ------------------------------------------------------------
	// A discarded prefetch is replaced by a no-operation word before decode, so neither
	// its opcode nor its file address can reach the array or the flags.
	logic [15:0] execWord;

	assign execWord = flushCycle_r ? INSTR_NOP : instrData;

	// The address is formed at the end of Q1 so that the read data settle through Q2.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			instr_r    <= INSTR_NOP;
			fileAddr_r <= '0;
			operand_r  <= '0;
		end else if (phase_r == PH_Q1) begin
			instr_r    <= execWord;
			fileAddr_r <= fileAddress(execWord, bankPointer);
		end else if (phase_r == PH_Q2) begin
			operand_r  <= fileRdData;
		end
	end

	// ------------------------------------------------------------
	// Q3 processing into the file write port
	// ------------------------------------------------------------
	// The strobe stands for the whole Q4 phase so the array can latch at any edge in it.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			fileWe_r     <= 1'b0;
			fileWrData_r <= '0;
		end else if (phase_r == PH_Q3) begin
			fileWe_r     <= writeFile;
			fileWrData_r <= resultNxt;
		end else begin
			fileWe_r     <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Q4 write-back and program counter
	// ------------------------------------------------------------
	// Reset starts in a discard cycle because no prefetched word exists yet.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			accum_r       <= ACCUM_RST;
			statusFlags_r <= FLAG_RST;
			pc_r          <= PC_RST;
			flushCycle_r  <= 1'b1;
			fetchStrobe_r <= 1'b1;
		end else if (phase_r == PH_Q4) begin
			if (writeAccum) begin
				accum_r <= resultNxt;
			end
			statusFlags_r <= flagsNxt;
			pc_r          <= pcNxt;
			flushCycle_r  <= brTaken;
			fetchStrobe_r <= 1'b1;
		end else begin
			fetchStrobe_r <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	// Every check is off while reset is low, because the ring restarts at Q1 and a
	// property spanning the reset edge would compare against a phase that never ran.

	phase_order_a: assert property (phase_r == PH_Q4 |=> phase_r == PH_Q1 ##3 phase_r == PH_Q4)
		else $error("Phase ring does not repeat every four clocks.");

	and_imm_result_a: assert property (phase_r == PH_Q4 && isAndImm |=>
		accum_r == ($past(accum_r) & $past(instr_r[7:0]))
		&& statusFlags_r[FLG_C] == $past(statusFlags_r[FLG_C]))
		else $error("AND immediate result or carry wrong.");

	and_file_dest_a: assert property (phase_r == PH_Q3 && isAndFile && destFile |=>
		fileWe_r && fileWrData_r == (accum_r & operand_r))
		else $error("AND file result not written to the file.");

	bit_clear_a: assert property (phase_r == PH_Q4 && isBitClr |->
		fileWe_r && fileWrData_r == (operand_r & ~bitMask(instr_r)) ##1 $stable(statusFlags_r))
		else $error("Bit clear wrong data or flags changed.");

	bank_select_a: assert property (phase_r == PH_Q2 && !instr_r[BANK_ACC_BIT] |->
		fileAddr_r[11:8] == (instr_r[7] ? WINDOW_HI_BANK : WINDOW_LO_BANK))
		else $error("Fixed window bank not used.");

	branch_target_a: assert property (phase_r == PH_Q4 && brTaken |=>
		pc_r == $past(pc_r) + {{12{$past(instr_r[7])}}, $past(instr_r[7:0]), 1'b0}
		&& statusFlags_r == $past(statusFlags_r))
		else $error("Taken branch target or flags wrong.");

	branch_extra_a: assert property (phase_r == PH_Q4 && brTaken |=>
		flushCycle_r[*4] ##1 !flushCycle_r)
		else $error("Taken branch does not add exactly one discard cycle.");

	discard_prefetch_a: assert property (phase_r == PH_Q1 && flushCycle_r |=>
		instr_r == INSTR_NOP ##2 !fileWe_r)
		else $error("Prefetched word executed after a taken branch.");

	// Each branch is judged by whether a discard cycle follows it.
	carry_cond_a: assert property (phase_r == PH_Q4 && isBrCs |=>
		flushCycle_r == $past(statusFlags_r[FLG_C]))
		else $error("Carry-set branch condition wrong.");

	neg_cond_a: assert property (phase_r == PH_Q4 && isBrNs |=>
		flushCycle_r == $past(statusFlags_r[FLG_N]))
		else $error("Negative-set branch condition wrong.");

	carry_clear_a: assert property (phase_r == PH_Q4 && isBrCc |=>
		flushCycle_r == !$past(statusFlags_r[FLG_C]))
		else $error("Carry-clear branch condition wrong.");

	seq_step_a: assert property (phase_r == PH_Q4 && !brTaken |=> pc_r == $past(pc_r) + PC_STEP)
		else $error("Sequential step not two.");

	// Add with carry is held against a sum formed here, independent of the unit.
	add_carry_sum_a: assert property (phase_r == PH_Q4 && isAddCarry |->
		{aluBus.carryOut, resultNxt}
		== {1'b0, accum_r} + {1'b0, operand_r} + {8'h00, statusFlags_r[FLG_C]})
		else $error("Add with carry sum wrong.");

	add_flag_load_a: assert property (phase_r == PH_Q4 && isAddCarry |=>
		statusFlags_r[FLG_C] == $past(aluBus.carryOut)
		&& statusFlags_r[FLG_DC] == $past(aluBus.digitCarry)
		&& statusFlags_r[FLG_OV] == $past(aluBus.overflow)
		&& statusFlags_r[FLG_N] == $past(resultNxt[7])
		&& statusFlags_r[FLG_Z] == ($past(resultNxt) == 8'h00))
		else $error("Add with carry flags not loaded.");

	and_file_flags_a: assert property (phase_r == PH_Q4 && isAndFile |=>
		statusFlags_r[FLG_N] == $past(accum_r[7] & operand_r[7])
		&& statusFlags_r[FLG_Z] == (($past(accum_r) & $past(operand_r)) == 8'h00)
		&& statusFlags_r[FLG_C] == $past(statusFlags_r[FLG_C])
		&& statusFlags_r[FLG_OV] == $past(statusFlags_r[FLG_OV]))
		else $error("AND file flags wrong.");

	accum_dest_a: assert property (phase_r == PH_Q4 && !destFile
		&& (isAndFile || isAddCarry) |-> !fileWe_r ##1 accum_r == $past(resultNxt))
		else $error("Accumulator destination not honoured.");

	// Strobes stand only in their own phase, so array and fetch never see stale requests.
	write_strobe_a: assert property (fileWe_r |-> phase_r == PH_Q4)
		else $error("File write outside Q4.");

	fetch_strobe_a: assert property (fetchStrobe_r |-> phase_r == PH_Q1)
		else $error("Fetch strobe outside Q1.");

endmodule // lbd_core

`default_nettype wire

/* tb/lbd_core_tb_top.sv */
// Purpose: Self-checking bench for the logic, bit-clear and branch decoder core.
// Assumes: Words are driven just after the edge ending Q4, so they are steady at the Q1 edge.
// Notes:   The file array is modelled here and starts cleared.
`default_nettype none

module lbd_core_tb_top
	import lbd_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------
	// Signals and file array model
	// ------------------------------------------------------------
	logic               core_clk;
	logic               rst_n;
	logic [15:0]        instrData;
	logic [3:0]         bankPointer;
	logic [DATA_W-1:0]  fileRdData;
	logic [PC_W-1:0]    pc_r;
	logic               fetchStrobe_r;
	logic               flushCycle_r;
	logic               fileWe_r;
	logic [FADDR_W-1:0] fileAddr_r;
	logic [DATA_W-1:0]  fileWrData_r;
	logic [DATA_W-1:0]  accum_r;
	logic [FLAG_W-1:0]  statusFlags_r;
	logic [DATA_W-1:0]  fileMem [0:4095];
	logic [3:0]         weSeen;
	logic [3:0]         fetchSeen;
	int                 error_cnt;
	int                 checks;

	lbd_core uut (
		.core_clk      (core_clk),
		.rst_n         (rst_n),
		.instrData     (instrData),
		.pc_r          (pc_r),
		.fetchStrobe_r (fetchStrobe_r),
		.flushCycle_r  (flushCycle_r),
		.bankPointer   (bankPointer),
		.fileRdData    (fileRdData),
		.fileAddr_r    (fileAddr_r),
		.fileWrData_r  (fileWrData_r),
		.fileWe_r      (fileWe_r),
		.accum_r       (accum_r),
		.statusFlags_r (statusFlags_r)
	);

	// Reads are combinational because the core samples them at the edge ending Q2.
	assign fileRdData = fileMem[fileAddr_r];

	// Writes land at the edge that closes Q4.
	always @(posedge core_clk) begin
		if (fileWe_r === 1'b1) begin
			fileMem[fileAddr_r] <= fileWrData_r;
		end
	end

	// The clock runs at 40 MHz.
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic chk(input string what, input logic [47:0] exp, input logic [47:0] got);
		checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	// One instruction cycle; the write and fetch strobes are sampled once per phase.
	task automatic issue(input logic [15:0] word);
		instrData <= word;
		for (int k = 0; k < 4; k++) begin
			@(posedge core_clk);
			#1 weSeen[k] = fileWe_r;
			fetchSeen[k] = fetchStrobe_r;
		end
	endtask

	// A taken branch is followed by a word that would clear the accumulator if it ran.
	task automatic branch(input logic [7:0] opc, input logic [7:0] n, input logic taken);
		logic [PC_W-1:0]   pc0;
		logic [PC_W-1:0]   pcExp;
		logic [DATA_W-1:0] w0;
		logic [FLAG_W-1:0] f0;
		pc0 = pc_r;
		w0 = accum_r;
		f0 = statusFlags_r;
		pcExp = taken ? pc0 + {{(PC_W-9){n[7]}}, n, 1'b0} : pc0 + PC_STEP;
		issue({opc, n});
		chk("branch pc", pcExp, pc_r);
		chk("branch flush and flags", {taken, f0}, {flushCycle_r, statusFlags_r});
		if (taken) begin
			issue(16'h0b00);
			chk("discard cycle", {pcExp + PC_STEP, 1'b0, w0}, {pc_r, flushCycle_r, accum_r});
		end
	endtask

	task automatic final_report;
		$display("Mismatches %0d, comparisons %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic test_reset;
		repeat (16) @(posedge core_clk);
		#1;
		chk("reset state", {PC_RST, 3'b110, ACCUM_RST, FLAG_RST},
			{pc_r, fetchStrobe_r, flushCycle_r, fileWe_r, accum_r, statusFlags_r});
		@(posedge core_clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge core_clk);
		#1;
		chk("first discard", {PC_STEP, 1'b0}, {pc_r, flushCycle_r});
	endtask

	task automatic test_add_carry;
		fileMem[12'h110] = 8'ha3;
		bankPointer <= 4'h1;
		issue(16'h2110);
		chk("add to accum", {8'ha3, 5'h10, 4'h0, 4'b1000},
			{accum_r, statusFlags_r, weSeen, fetchSeen});
	endtask

	task automatic test_and_file;
		fileMem[12'hf85] = 8'hc2;
		bankPointer <= 4'h3;
		issue(16'h1685);
		chk("and to file", {8'h82, 8'ha3, 5'h10, 4'b0100},
			{fileMem[12'hf85], accum_r, statusFlags_r, weSeen});
		chk("pointer ignored", 8'h00, fileMem[12'h385]);
	endtask

	task automatic test_bit_clear;
		bankPointer <= 4'h1;
		issue(16'h9f10);
		chk("bit clear", {8'h23, 8'ha3, 5'h10, 4'b0100},
			{fileMem[12'h110], accum_r, statusFlags_r, weSeen});
	endtask

	task automatic test_and_window;
		fileMem[12'h020] = 8'h0f;
		bankPointer <= 4'h2;
		issue(16'h1420);
		chk("and to accum", {8'h03, 5'h00, 4'h0}, {accum_r, statusFlags_r, weSeen});
	endtask

	// Carry comes only from adds, so the adds here set up the conditions of the five branches after them.
	task automatic test_branches;
		branch(OPC_BR_CS, 8'h05, 1'b0);
		branch(OPC_BR_NS, 8'h7f, 1'b0);
		branch(OPC_BR_CC, 8'h80, 1'b1);
		fileMem[12'h111] = 8'hff;
		fileMem[12'h112] = 8'h7f;
		bankPointer <= 4'h1;
		issue(16'h2111);
		chk("carry add", {8'h02, 5'h03}, {accum_r, statusFlags_r});
		branch(OPC_BR_CS, 8'hff, 1'b1);
		branch(OPC_BR_NS, 8'h05, 1'b0);
		branch(OPC_BR_CC, 8'h05, 1'b0);
		issue(16'h2112);
		chk("overflow add", {8'h82, 5'h1a}, {accum_r, statusFlags_r});
		branch(OPC_BR_NS, 8'h7f, 1'b1);
		branch(OPC_BR_CC, 8'h05, 1'b1);
	endtask

	task automatic test_and_imm;
		issue(16'h0b5f);
		chk("and literal", {8'h02, 5'h0a, 4'h0}, {accum_r, statusFlags_r, weSeen});
		issue(16'h2311);
		chk("add to file", {8'h01, 8'h02, 5'h03, 4'b0100},
			{fileMem[12'h111], accum_r, statusFlags_r, weSeen});
		issue(16'h0b7d);
		chk("and literal zero", {8'h00, 5'h07}, {accum_r, statusFlags_r});
	endtask

	// ------------------------------------------------------------
	// Main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		error_cnt = 0;
		checks = 0;
		rst_n = 1'b0;
		instrData = INSTR_NOP;
		bankPointer = 4'h0;
		for (int i = 0; i < 4096; i++) begin
			fileMem[i] = 8'h00;
		end
		test_reset();
		test_add_carry();
		test_and_file();
		test_bit_clear();
		test_and_window();
		test_branches();
		test_and_imm();
		final_report();
	end

	// The run needs about 105 clocks; this limit is far beyond that.
	initial begin
		#(25 * 3000);
		error_cnt++;
		final_report();
	end

endmodule // lbd_core_tb_top

`default_nettype wire
